// >>> hw/gsr_top.sv
// Purpose: Live pin level readback over AXI4-Lite, plus output drive of GPIO-output pins
// Assumes: Pins and bus share I_CLK; one write and one read outstanding at most
// Notes: Pin levels pass two flops before any read sees them
//        Writes get OKAY at decoded words and SLVERR elsewhere, and are dropped; nothing here is writable
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "gsr_map.svh"

module gsr_top
(
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RSTN,
	// Pads and output control
	input wire logic [`GSR_PIN_COUNT-1:0] I_PIN_IN,
	input wire logic [`GSR_PIN_COUNT-1:0] I_OUT_CTRL,
	input wire logic [`GSR_PIN_COUNT-1:0] I_GPO_SEL,
	output logic [`GSR_PIN_COUNT-1:0] O_PIN_OUT,
	output logic [`GSR_PIN_COUNT-1:0] O_PIN_OE_N,
	// AXI4-Lite write address and data
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [`GSR_ADDR_W-1:0] I_AWADDR,
	input wire logic I_WVALID,
	output logic O_WREADY,
	input wire logic [`GSR_DATA_W-1:0] I_WDATA,
	// AXI4-Lite write response
	output logic O_BVALID,
	input wire logic I_BREADY,
	output logic [1:0] O_BRESP,
	// AXI4-Lite read
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	input wire logic [`GSR_ADDR_W-1:0] I_ARADDR,
	output logic O_RVALID,
	input wire logic I_RREADY,
	output logic [`GSR_DATA_W-1:0] O_RDATA,
	output logic [1:0] O_RRESP
);

	// Whole register state and its next value
	gsr_pkg::gsr_state_t st;
	gsr_pkg::gsr_state_t next_st;
	// Handshakes that complete at this edge
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic [`GSR_ADDR_W-1:0] next_aw_addr;

	// True for any of the three decoded words
	function automatic logic addr_hit(input logic [`GSR_ADDR_W-1:0] addr);
		addr_hit = (addr == `GSR_ADDR_LEVEL_LOW) || (addr == `GSR_ADDR_LEVEL_HIGH)
			|| (addr == `GSR_ADDR_BUS_MONITOR);
	endfunction

	// Read mux: {resp, data}; the monitor word has nothing behind it and reads zero
	function automatic logic [`GSR_DATA_W+1:0] read_word(
		input logic [`GSR_ADDR_W-1:0] addr,
		input logic [`GSR_PIN_COUNT-1:0] lvl
	);
		// Unmapped addresses fall through to an error answer with zero data
		read_word = {`GSR_RESP_SLVERR, `GSR_WORD_ZERO};
		if (addr == `GSR_ADDR_LEVEL_LOW)
		begin
			read_word = {`GSR_RESP_OKAY, lvl[`GSR_LOW_PINS-1:0]};
		end
		else if (addr == `GSR_ADDR_LEVEL_HIGH)
		begin
			read_word = {`GSR_RESP_OKAY, {`GSR_HIGH_RSVD_W{1'b0}},
				lvl[`GSR_PIN_COUNT-1:`GSR_LOW_PINS]};
		end
		else if (addr == `GSR_ADDR_BUS_MONITOR)
		begin
			read_word = {`GSR_RESP_OKAY, `GSR_WORD_ZERO};
		end
	endfunction

	// Ready while nothing of that channel is parked and no response is pending
	assign O_AWREADY = !st.aw_held && !st.bvalid;
	assign O_WREADY = !st.w_held && !st.bvalid;
	assign O_ARREADY = !st.rvalid;
	// A channel moves at the edge where its valid meets its ready
	assign aw_take = I_AWVALID && O_AWREADY;
	assign w_take = I_WVALID && O_WREADY;
	assign ar_take = I_ARVALID && O_ARREADY;
	assign next_aw_addr = aw_take ? I_AWADDR : st.aw_addr;

	// Next state of every flop
	always_comb
	begin
		next_st = st;
		// Pads sampled twice; stage a feeds stage b only, so no read sees a metastable bit
		next_st.sync_a = I_PIN_IN;
		next_st.sync_b = st.sync_a;
		// Output drivers follow control bits only where the pin is a GPIO output
		// Unselected pins drive low with the enable off, so no stale level leaks out
		next_st.pin_out = I_OUT_CTRL & I_GPO_SEL;
		next_st.pin_oe_n = ~I_GPO_SEL;
		// Write path: address and data may come in either order
		// A second write waits on BVALID, so one response at most is outstanding
		if (aw_take)
		begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = I_AWADDR;
		end
		if (w_take)
		begin
			next_st.w_held = 1'b1;
		end
		// Every word here is read-only or unused, so write data is dropped
		if (next_st.aw_held && next_st.w_held && !st.bvalid)
		begin
			next_st.bvalid = 1'b1;
			next_st.bresp = addr_hit(next_aw_addr) ? `GSR_RESP_OKAY : `GSR_RESP_SLVERR;
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
		end
		if (st.bvalid && I_BREADY)
		begin
			next_st.bvalid = 1'b0;
		end
		// Read path: data captured at the address handshake, so RDATA stands unchanged
		// until RREADY even while the pads move on underneath it
		if (ar_take)
		begin
			next_st.rvalid = 1'b1;
			{next_st.rresp, next_st.rdata} = read_word(I_ARADDR, st.sync_b);
		end
		else if (st.rvalid && I_RREADY)
		begin
			next_st.rvalid = 1'b0;
		end
	end

	// State register; synchroniser clears too, but refills from the pads two edges later
	// Limitation: a read taken in the first two edges after release sees the cleared
	// stages, so software should allow two clocks before trusting the status words
	always_ff @(posedge I_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			st <= '0;
			st.pin_oe_n <= {`GSR_PIN_COUNT{1'b1}}; // Pads released until configured
		end
		else
		begin
			st <= next_st;
		end
	end

	// Port drive, all from flops
	assign O_PIN_OUT = st.pin_out;
	assign O_PIN_OE_N = st.pin_oe_n;
	assign O_BVALID = st.bvalid;
	assign O_BRESP = st.bresp;
	assign O_RVALID = st.rvalid;
	assign O_RDATA = st.rdata;
	assign O_RRESP = st.rresp;

	// All checks run on I_CLK and stand down while reset is low
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_RSTN);

	// Checks on the readback path: pin fields and reserved bits of the status words
	a_high_word_pins: assert property (
		($past(ar_take) && $past(I_ARADDR) == `GSR_ADDR_LEVEL_HIGH && $past(I_RSTN, 3))
		|-> O_RDATA[`GSR_HIGH_MSB:0] == $past(I_PIN_IN[`GSR_PIN_COUNT-1:`GSR_LOW_PINS], 3))
		else $error("high word does not show pins 32-49");
	a_high_rsvd_zero: assert property (
		(O_RVALID && $past(I_ARADDR) == `GSR_ADDR_LEVEL_HIGH && $past(ar_take))
		|-> O_RDATA[`GSR_DATA_W-1:`GSR_HIGH_RSVD_LSB] == '0 && O_RRESP == `GSR_RESP_OKAY)
		else $error("high word reserved bits not zero");
	a_low_word_pins: assert property (
		($past(ar_take) && $past(I_ARADDR) == `GSR_ADDR_LEVEL_LOW && $past(I_RSTN, 3))
		|-> O_RDATA == $past(I_PIN_IN[`GSR_LOW_PINS-1:0], 3))
		else $error("low word does not show pins 0-31");
	// Synchroniser fill and depth
	a_follow_after_reset: assert property (
		$rose(I_RSTN) |-> ##2 st.sync_b == $past(I_PIN_IN, 2))
		else $error("status not following pads after reset");
	a_any_config: assert property (
		($past(I_RSTN, 2) && $past(I_GPO_SEL, 2) != '0)
		|-> st.sync_b == $past(I_PIN_IN, 2))
		else $error("status lost pad level in output configuration");
	// Pad drive, synchroniser depth and status path untouched by writes
	a_gpo_drive: assert property (
		$past(I_RSTN) |-> O_PIN_OE_N == ~$past(I_GPO_SEL)
		&& (O_PIN_OUT & $past(I_GPO_SEL)) == ($past(I_OUT_CTRL) & $past(I_GPO_SEL)))
		else $error("GPIO output pin not driven from control bit");
	a_two_stage_sync: assert property (
		$past(I_RSTN, 2) |-> st.sync_b == $past(I_PIN_IN, 2) && st.sync_b == $past(st.sync_a))
		else $error("synchroniser depth is not two");
	a_write_no_effect: assert property (
		(O_BVALID && !$past(O_BVALID)) |-> st.sync_b == $past(st.sync_a))
		else $error("write disturbed the status path");

	// Status word reads always answer OKAY one edge after the handshake
	a_read_answer: assert property (
		(ar_take && (I_ARADDR == `GSR_ADDR_LEVEL_LOW || I_ARADDR == `GSR_ADDR_LEVEL_HIGH))
		|=> O_RVALID && O_RRESP == `GSR_RESP_OKAY)
		else $error("status word read not answered OKAY");
	// A write to the high word is accepted and leaves the read data alone
	a_write_ignored: assert property (
		(aw_take && w_take && !ar_take && I_AWADDR == `GSR_ADDR_LEVEL_HIGH)
		|=> O_BVALID && O_BRESP == `GSR_RESP_OKAY && $stable(O_RDATA))
		else $error("write to high word not ignored");
	// Pins that are not GPIO outputs never carry a driven level
	a_unsel_pad_quiet: assert property (
		$past(I_RSTN) |-> (O_PIN_OUT & ~$past(I_GPO_SEL)) == '0)
		else $error("pin not set as GPIO output is driving a level");

endmodule

`default_nettype wire

// >>> shared/gsr_map.svh
// Purpose: Addresses, widths, field positions and response codes of the pin level readback
// Assumes: Byte addresses on a 32-bit AXI4-Lite register bus
// Notes: Definitions only; included by the package and the top module
`ifndef GSR_MAP_SVH
`define GSR_MAP_SVH

// Pin and word geometry
`define GSR_PIN_COUNT 50
`define GSR_LOW_PINS 32
`define GSR_HIGH_PINS 18
`define GSR_DATA_W 32
`define GSR_ADDR_W 32

// Register byte addresses
`define GSR_ADDR_LEVEL_LOW 32'h90600040
`define GSR_ADDR_LEVEL_HIGH 32'h90600044
`define GSR_ADDR_BUS_MONITOR 32'h90600050

// Field positions and fixed values
`define GSR_HIGH_MSB 17
`define GSR_HIGH_RSVD_LSB 18
`define GSR_HIGH_RSVD_W 14
`define GSR_WORD_ZERO 32'h00000000

// Bus response codes
`define GSR_RESP_OKAY 2'h0
`define GSR_RESP_SLVERR 2'h2

`endif

// >>> shared/gsr_pkg.sv
// Purpose: Types shared by the pin level readback
// Assumes: gsr_map.svh gives every width
// Notes: The state struct holds every flip-flop of the top module
`default_nettype none
`include "gsr_map.svh"

package gsr_pkg;

	// Whole register state of the top module
	typedef struct packed {
		logic [`GSR_PIN_COUNT-1:0] sync_a;
		logic [`GSR_PIN_COUNT-1:0] sync_b;
		logic [`GSR_PIN_COUNT-1:0] pin_out;
		logic [`GSR_PIN_COUNT-1:0] pin_oe_n;
		logic aw_held;
		logic [`GSR_ADDR_W-1:0] aw_addr;
		logic w_held;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [`GSR_DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} gsr_state_t;

endpackage

`default_nettype wire

// >>> test/gsr_pad_model.sv
// Purpose: Pad ring beside the pin level readback
// Assumes: Outside world drives every pad that the block leaves undriven
// Notes: Purely combinational, so pad levels settle within the cycle
`timescale 1ns/1ps
`default_nettype none
`include "gsr_map.svh"
module gsr_pad_model
(
	// Outside levels and block drive
	input wire logic [`GSR_PIN_COUNT-1:0] i_ext,
	input wire logic [`GSR_PIN_COUNT-1:0] i_drv,
	input wire logic [`GSR_PIN_COUNT-1:0] i_oe_n,
	// Resolved pad levels
	output logic [`GSR_PIN_COUNT-1:0] o_pad
);
	// Driven pads carry the drive, the rest the outside level
	assign o_pad = (i_drv & ~i_oe_n) | (i_ext & i_oe_n);
endmodule
`default_nettype wire

// >>> test/test_gsr_top.sv
// Purpose: Self-checking bench for the pin level readback
// Assumes: Random pads and drive selects from a bench LFSR
// Notes: Waits four edges after pad changes to cover the synchroniser
`timescale 1ns/1ps
`default_nettype none
`include "gsr_map.svh"
module test_gsr_top;
	logic clk, rstn, awv, wv, bre, arv, rre, awr, wr, bv, arr, rv;
	logic [31:0] awa, wd, ara, rd, lfsr;
	logic [1:0] br, rr;
	logic [49:0] ext, ctl, sel, pad, drv, oen, lvl;
	int mismatches, n_compared;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	gsr_pad_model i_pad (.i_ext(ext), .i_drv(drv), .i_oe_n(oen), .o_pad(pad));
	gsr_top i_dut (.I_CLK(clk), .I_RSTN(rstn), .I_PIN_IN(pad), .I_OUT_CTRL(ctl),
		.I_GPO_SEL(sel), .O_PIN_OUT(drv), .O_PIN_OE_N(oen), .I_AWVALID(awv),
		.O_AWREADY(awr), .I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wr), .I_WDATA(wd),
		.O_BVALID(bv), .I_BREADY(bre), .O_BRESP(br), .I_ARVALID(arv), .O_ARREADY(arr),
		.I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rre), .O_RDATA(rd), .O_RRESP(rr));
	function automatic logic [31:0] nxt(input logic [31:0] s);
		nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic cmp_word(input logic [33:0] e, input logic [33:0] g);
		n_compared++;
		if (g !== e)
		begin
			mismatches++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic cmp_resp(input logic [1:0] e, input logic [1:0] g);
		cmp_word({32'h0, e}, {32'h0, g});
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Address and data offered together, each released once its ready reads high after an edge
	task automatic wr_reg(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
		bq.push_back(e);
		awv <= 1'b1;
		wv <= 1'b1;
		awa <= a;
		wd <= d;
		@(posedge clk);
		while (awv || wv)
		begin
			if (awr)
				awv <= 1'b0;
			if (wr)
				wv <= 1'b0;
			@(posedge clk);
		end
		while (!bv)
			@(posedge clk);
	endtask
	task automatic rd_reg(input logic [31:0] a, input logic [33:0] e);
		rq.push_back(e);
		arv <= 1'b1;
		ara <= a;
		@(posedge clk);
		while (!arr)
			@(posedge clk);
		arv <= 1'b0;
		@(posedge clk);
		while (!rv)
			@(posedge clk);
	endtask
	// Oldest note against each answer
	always @(posedge clk)
	begin
		if (rv && rre)
			cmp_word(rq.pop_front(), {rr, rd});
		if (bv && bre)
			cmp_resp(bq.pop_front(), br);
	end
	initial
	begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		end_of_test();
	end
	initial
	begin
		{rstn, awv, wv, arv, awa, wd, ara, ext, ctl, sel} = '0;
		{bre, rre} = 2'h3;
		lfsr = 32'h0e91dc1d;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			lfsr = nxt(lfsr);
			ext <= {lfsr[17:0], nxt(lfsr)};
			lfsr = nxt(nxt(lfsr));
			sel <= i[0] ? {lfsr[31:14], nxt(lfsr)} : 50'h0;
			ctl <= {nxt(lfsr), lfsr[17:0]};
			repeat (4) @(posedge clk);
			lvl = (ctl & sel) | (ext & ~sel);
			rd_reg(`GSR_ADDR_LEVEL_LOW, {`GSR_RESP_OKAY, lvl[31:0]});
			rd_reg(`GSR_ADDR_LEVEL_HIGH, {`GSR_RESP_OKAY, 14'h0, lvl[49:32]});
			wr_reg(`GSR_ADDR_LEVEL_HIGH, lfsr, `GSR_RESP_OKAY);
			rd_reg(`GSR_ADDR_LEVEL_HIGH, {`GSR_RESP_OKAY, 14'h0, lvl[49:32]});
		end
		// Monitor word: the write is dropped with OKAY, and the word reads zero with nothing behind it
		wr_reg(`GSR_ADDR_BUS_MONITOR, `GSR_WORD_ZERO, `GSR_RESP_OKAY);
		rd_reg(`GSR_ADDR_BUS_MONITOR, {`GSR_RESP_OKAY, `GSR_WORD_ZERO});
		rd_reg(32'h90600048, {`GSR_RESP_SLVERR, `GSR_WORD_ZERO});
		wr_reg(32'h90600048, lfsr, `GSR_RESP_SLVERR);
		// Mid-run reset: status must come back as the pads, not a fixed value
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		rd_reg(`GSR_ADDR_LEVEL_LOW, {`GSR_RESP_OKAY, lvl[31:0]});
		repeat (2) @(posedge clk);
		end_of_test();
	end
endmodule
`default_nettype wire
